// *** gss_sync_serial_port.sv ***
// Clock-synchronous serial channel with trigger-aligned transfer clock
//
// Operation
// - Words are eight data bits, no framing
// - Clock source bit one: clock from pin
// - Start needs enables, data, then trigger
// - Trigger pin aligns clock, not flow control
// - Source zero: transmit interrupt at load
// - Source one: transmit interrupt after last bit
// - Receive interrupt when word reaches buffer
// - Overrun if seventh bit meets unread buffer
// - Overrun: buffer undefined, receive flag not set
// - Flow select ignored, flow disable is one
// - Status flag: transmit shifter empty
// - Status flag: transmit buffer empty
// - Control bit picks output driver format
// - Program sync select, then trigger aligns
// - Sync select: none, same, half rate
// - Derived clock: external period or half rate
// - Run-control bit starts or stops transfer clock
// - Transmit enable plus receive enable both needed
`timescale 1ns/10ps
`default_nettype none
module gss_sync_serial_port
  import gss_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic        transfer_clock_pin_in,
  input  wire logic        sync_trigger_pin_n_in,
  input  wire logic        serial_in_pin_in,
  output logic             serial_out_pin_out,
  output logic             serial_out_pin_oe_out,
  output logic             irq_out
);

  function automatic logic gss_mapped(input logic [7:0] a);
    gss_mapped = (a <= GSS_A_IMSK) && (a[1:0] == 2'b00);
  endfunction : gss_mapped

  gss_state_t  state_q;
  logic [7:0]  txbuf_q;
  logic [7:0]  rxbuf_q;
  logic [7:0]  brg_q;
  logic [7:0]  mode_q;
  logic [7:0]  ctl0_q;
  logic [7:0]  ctl1_q;
  logic [7:0]  smr1_q;
  logic [7:0]  smr2_q;
  logic [7:0]  smr3_q;
  logic [7:0]  smr4_q;
  logic        tbe_q;
  logic        rdone_q;
  logic        ovr_q;
  logic        sempty_q;
  logic [2:0]  ist_q;
  logic [2:0]  imsk_q;
  logic [31:0] prdata_q;
  logic [7:0]  tsh_q;
  logic [7:0]  rsh_q;
  logic [3:0]  cnt_q;
  logic        ovr_word_q;
  logic        out_q;
  logic        phase_q;
  logic        ck_s1, ck_s2, ck_s3;
  logic        tg_s1, tg_s2, tg_s3;
  logic        rx_s1, rx_s2;

  logic access, wr, rd, setup;
  logic ext_rise, ext_fall, trig, run, half, same;
  logic t_rise, t_fall, start_ok, ev_load, ev_rx, ev_txdone, ev_ovr, ev_txi;

  assign setup  = psel_in && !penable_in;
  assign access = psel_in && penable_in;
  assign wr     = access && pwrite_in && gss_mapped(paddr_in);
  assign rd     = access && !pwrite_in && gss_mapped(paddr_in);

  // Slave answers in the first access cycle; read data was staged at setup
  assign pready_out  = 1'b1;
  assign pslverr_out = access && !gss_mapped(paddr_in);
  assign prdata_out  = prdata_q;

  // Pins cross into clk_in through two flops before any use
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      {ck_s1, ck_s2, ck_s3} <= 3'h0;
      {tg_s1, tg_s2, tg_s3} <= 3'h7;
      {rx_s1, rx_s2}        <= 2'h3;
    end
    else
    begin
      ck_s1 <= transfer_clock_pin_in;
      ck_s2 <= ck_s1;
      ck_s3 <= ck_s2;
      tg_s1 <= sync_trigger_pin_n_in;
      tg_s2 <= tg_s1;
      tg_s3 <= tg_s2;
      rx_s1 <= serial_in_pin_in;
      rx_s2 <= rx_s1;
    end
  end

  assign ext_rise = ck_s2 && !ck_s3;
  assign ext_fall = !ck_s2 && ck_s3;
  // Trigger is the falling edge of the active-low pin, never a flow gate
  assign trig     = !tg_s2 && tg_s3;
  assign run      = mode_q[GSS_MR_CKSRC] && !ctl1_q[GSS_C1_STOP];
  assign half     = smr1_q[GSS_SMR1_HALF];
  assign same     = !half && smr2_q[GSS_SMR2_SAME];

  // Half rate: two external rises make one derived period, phase reset by trigger
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      phase_q <= 1'b0;
    else if (trig && (half || same))
      phase_q <= 1'b0;
    else if (ext_rise && run && half)
      phase_q <= !phase_q;
  end

  always_comb
  begin
    if (half)
    begin
      t_rise = run && ext_rise && phase_q;
      t_fall = run && ext_rise && !phase_q;
    end
    else
    begin
      t_rise = run && ext_rise;
      t_fall = run && ext_fall;
    end
  end

  // Transmit enable alone is not enough; receive enable must join it
  assign start_ok  = ctl1_q[GSS_C1_TE] && ctl1_q[GSS_C1_RE] && !tbe_q && run;
  assign ev_load   = (state_q == GSS_IDLE && start_ok && trig)
                  || (state_q == GSS_SHIFT && t_fall && cnt_q == GSS_WORD_END && start_ok);
  assign ev_rx     = state_q == GSS_SHIFT && t_rise && cnt_q == GSS_LAST_BIT;
  assign ev_ovr    = state_q == GSS_SHIFT && t_rise && cnt_q == GSS_OVR_BIT && rdone_q;
  assign ev_txdone = state_q == GSS_SHIFT && t_fall && cnt_q == GSS_WORD_END;
  assign ev_txi    = ctl1_q[GSS_C1_IRS] ? ev_txdone : ev_load;

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      state_q <= GSS_IDLE;
    else
      case (state_q)
        GSS_IDLE:  if (ev_load) state_q <= GSS_SHIFT;
        GSS_SHIFT: if (ev_txdone && !ev_load) state_q <= GSS_IDLE;
        default:   state_q <= GSS_IDLE;
      endcase
  end

  // Shift engine: LSB first, out on falling, in on rising edge
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      tsh_q <= GSS_BYTE_RST;
      rsh_q <= GSS_BYTE_RST;
      cnt_q <= 4'h0;
      out_q <= 1'b1;
    end
    else if (ev_load)
    begin
      tsh_q <= txbuf_q;
      out_q <= txbuf_q[0];
      cnt_q <= 4'h0;
    end
    else if (state_q == GSS_SHIFT)
    begin
      if (t_rise && cnt_q <= GSS_LAST_BIT)
      begin
        rsh_q <= {rx_s2, rsh_q[7:1]};
        cnt_q <= cnt_q + 4'h1;
      end
      if (t_fall && cnt_q != 4'h0 && cnt_q < GSS_WORD_END)
      begin
        tsh_q <= {1'b0, tsh_q[7:1]};
        out_q <= tsh_q[1];
      end
      if (ev_txdone)
        out_q <= 1'b1;
    end
  end

  // Overrun seen at the seventh bit (index six) spoils the whole word
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      ovr_word_q <= 1'b0;
    else if (ev_load)
      ovr_word_q <= 1'b0;
    else if (ev_ovr)
      ovr_word_q <= 1'b1;
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      rxbuf_q <= GSS_BYTE_RST;
    else if (ev_rx)
      rxbuf_q <= {rx_s2, rsh_q[7:1]};
  end

  // Hardware sets win over software clears on every flag
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      tbe_q    <= 1'b1;
      sempty_q <= 1'b1;
      rdone_q  <= 1'b0;
      ovr_q    <= 1'b0;
    end
    else
    begin
      if (ev_load)
        tbe_q <= 1'b1;
      else if (wr && paddr_in == GSS_A_TXBUF)
        tbe_q <= 1'b0;
      if (ev_load)
        sempty_q <= 1'b0;
      else if (ev_txdone)
        sempty_q <= 1'b1;
      if (ev_rx && !ovr_word_q && !ev_ovr)
        rdone_q <= 1'b1;
      else if (rd && paddr_in == GSS_A_RXBUF)
        rdone_q <= 1'b0;
      if (ev_ovr)
        ovr_q <= 1'b1;
      else if (wr && paddr_in == GSS_A_CTL1 && !pwdata_in[GSS_C1_RE])
        ovr_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      ist_q <= 3'h0;
    else
    begin
      ist_q[GSS_IS_TX]  <= ev_txi || (ist_q[GSS_IS_TX]
                         && !(wr && paddr_in == GSS_A_IST && pwdata_in[GSS_IS_TX]));
      ist_q[GSS_IS_RX]  <= (ev_rx && !ovr_word_q && !ev_ovr) || (ist_q[GSS_IS_RX]
                         && !(wr && paddr_in == GSS_A_IST && pwdata_in[GSS_IS_RX]));
      ist_q[GSS_IS_OVR] <= ev_ovr || (ist_q[GSS_IS_OVR]
                         && !(wr && paddr_in == GSS_A_IST && pwdata_in[GSS_IS_OVR]));
    end
  end

  assign irq_out = |(ist_q & imsk_q);

  // Software registers; bit-rate divider kept only for readback in this mode
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      txbuf_q <= GSS_BYTE_RST;
      brg_q   <= GSS_BYTE_RST;
      mode_q  <= GSS_BYTE_RST;
      ctl0_q  <= GSS_CTL0_RST;
      ctl1_q  <= GSS_BYTE_RST;
      smr1_q  <= GSS_BYTE_RST;
      smr2_q  <= GSS_BYTE_RST;
      smr3_q  <= GSS_BYTE_RST;
      smr4_q  <= GSS_BYTE_RST;
      imsk_q  <= 3'h0;
    end
    else if (wr)
      case (paddr_in)
        GSS_A_TXBUF: txbuf_q <= pwdata_in[7:0];
        GSS_A_BRG:   brg_q   <= pwdata_in[7:0];
        GSS_A_MODE:  mode_q  <= pwdata_in[7:0];
        GSS_A_CTL0:  ctl0_q  <= pwdata_in[7:0] | GSS_CTL0_RST;
        GSS_A_CTL1:  ctl1_q  <= pwdata_in[7:0];
        GSS_A_SMR1:  smr1_q  <= pwdata_in[7:0];
        GSS_A_SMR2:  smr2_q  <= pwdata_in[7:0];
        GSS_A_SMR3:  smr3_q  <= pwdata_in[7:0];
        GSS_A_SMR4:  smr4_q  <= pwdata_in[7:0];
        GSS_A_IMSK:  imsk_q  <= pwdata_in[2:0];
        default:     imsk_q  <= imsk_q;
      endcase
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      prdata_q <= 32'h0;
    else if (setup)
      case (paddr_in)
        GSS_A_RXBUF: prdata_q <= {16'h0, ovr_q, 7'h0, rxbuf_q};
        GSS_A_BRG:   prdata_q <= {24'h0, brg_q};
        GSS_A_MODE:  prdata_q <= {24'h0, mode_q};
        GSS_A_CTL0:  prdata_q <= {24'h0, ctl0_q[7:4], sempty_q, ctl0_q[2:0]};
        GSS_A_CTL1:  prdata_q <= {24'h0, ctl1_q[7:4], rdone_q, ctl1_q[2], tbe_q,
                                  ctl1_q[0]};
        GSS_A_SMR1:  prdata_q <= {24'h0, smr1_q};
        GSS_A_SMR2:  prdata_q <= {24'h0, smr2_q};
        GSS_A_SMR3:  prdata_q <= {24'h0, smr3_q};
        GSS_A_SMR4:  prdata_q <= {24'h0, smr4_q};
        GSS_A_IST:   prdata_q <= {29'h0, ist_q};
        GSS_A_IMSK:  prdata_q <= {29'h0, imsk_q};
        default:     prdata_q <= 32'h0;
      endcase
  end

  // Open drain only pulls low; push-pull always drives
  assign serial_out_pin_out    = out_q;
  assign serial_out_pin_oe_out = ctl0_q[GSS_C0_ODF] ? !out_q : 1'b1;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  a_start_needs_cond: assert property (
    (state_q == GSS_IDLE && ev_load) |-> (ctl1_q[GSS_C1_TE] && ctl1_q[GSS_C1_RE]
      && !tbe_q && !tg_s2 && tg_s3))
    else $error("start without conditions");
  a_ext_clock_only: assert property (
    !mode_q[GSS_MR_CKSRC] |-> !t_rise && !t_fall && !ev_load)
    else $error("tick without external clock source");
  a_clock_stopped: assert property (
    ctl1_q[GSS_C1_STOP] |-> !t_rise && !t_fall)
    else $error("tick while transfer clock stopped");
  a_tx_irq_early: assert property (
    (ev_load && !ctl1_q[GSS_C1_IRS]) |=> ist_q[GSS_IS_TX] && tbe_q)
    else $error("transmit interrupt missing at load");
  a_tx_irq_late: assert property (
    (state_q == GSS_IDLE && ev_load && ctl1_q[GSS_C1_IRS] && !ist_q[GSS_IS_TX] && !wr)
      |=> !ist_q[GSS_IS_TX])
    else $error("transmit interrupt too early");
  a_word_eight_bits: assert property (
    ev_rx |-> cnt_q == GSS_LAST_BIT ##1 cnt_q == GSS_WORD_END)
    else $error("word length not eight");
  a_rx_irq_sets: assert property (
    (ev_rx && !ovr_word_q && !ev_ovr) |=> rdone_q && ist_q[GSS_IS_RX])
    else $error("receive completion not flagged");
  a_overrun_flag: assert property (
    ev_ovr |=> ovr_q && ist_q[GSS_IS_OVR])
    else $error("overrun not flagged");
  a_overrun_no_rx: assert property (
    (ev_rx && ovr_word_q && !ist_q[GSS_IS_RX] && !wr) |=> !ist_q[GSS_IS_RX])
    else $error("receive flag set on overrun");
  a_shifter_busy: assert property (
    (state_q == GSS_SHIFT && !ev_txdone) |=> !sempty_q)
    else $error("shifter empty during word");
  a_open_drain: assert property (
    (ctl0_q[GSS_C0_ODF] && serial_out_pin_out) |-> !serial_out_pin_oe_out)
    else $error("open drain drives high");
  a_half_rate: assert property (
    (half && t_rise) |-> !$past(t_rise) && !t_fall)
    else $error("half rate tick pattern wrong");

  c_word_loaded:  cover property (ev_load ##[1:1000] ev_txdone);
  c_rx_complete:  cover property (ev_rx && !ovr_word_q);
  c_overrun:      cover property (ev_ovr);
  c_half_rate_rx: cover property (half && ev_rx);

endmodule : gss_sync_serial_port
`default_nettype wire

// *** gss_pkg.sv ***
// Constants and types for the synchronous serial channel
package gss_pkg;
  // Register byte addresses
  localparam logic [7:0] GSS_A_TXBUF = 8'h00;
  localparam logic [7:0] GSS_A_RXBUF = 8'h04;
  localparam logic [7:0] GSS_A_BRG   = 8'h08;
  localparam logic [7:0] GSS_A_MODE  = 8'h0C;
  localparam logic [7:0] GSS_A_CTL0  = 8'h10;
  localparam logic [7:0] GSS_A_CTL1  = 8'h14;
  localparam logic [7:0] GSS_A_SMR1  = 8'h18;
  localparam logic [7:0] GSS_A_SMR2  = 8'h1C;
  localparam logic [7:0] GSS_A_SMR3  = 8'h20;
  localparam logic [7:0] GSS_A_SMR4  = 8'h24;
  localparam logic [7:0] GSS_A_IST   = 8'h28;
  localparam logic [7:0] GSS_A_IMSK  = 8'h2C;
  // Field positions
  localparam int GSS_MR_CKSRC  = 3;
  localparam int GSS_C0_ODF    = 2;
  localparam int GSS_C0_SEMPTY = 3;
  localparam int GSS_C0_FPD    = 4;
  localparam int GSS_C0_FPFS   = 5;
  localparam int GSS_C1_TE     = 0;
  localparam int GSS_C1_TBE    = 1;
  localparam int GSS_C1_RE     = 2;
  localparam int GSS_C1_RDONE  = 3;
  localparam int GSS_C1_IRS    = 4;
  localparam int GSS_C1_STOP   = 5;
  localparam int GSS_SMR1_HALF = 7;
  localparam int GSS_SMR2_SAME = 7;
  localparam int GSS_RB_OVR    = 15;
  localparam int GSS_IS_TX     = 0;
  localparam int GSS_IS_RX     = 1;
  localparam int GSS_IS_OVR    = 2;
  // Reset values
  localparam logic [7:0] GSS_CTL0_RST = 8'h10;
  localparam logic [7:0] GSS_BYTE_RST = 8'h00;
  // Word shape: bit count and the bit index at which overrun is judged
  localparam logic [3:0] GSS_LAST_BIT = 4'h7;
  localparam logic [3:0] GSS_OVR_BIT  = 4'h6;
  localparam logic [3:0] GSS_WORD_END = 4'h8;
  typedef enum logic [1:0]
  {
    GSS_IDLE  = 2'b00,
    GSS_SHIFT = 2'b01
  } gss_state_t;
endpackage : gss_pkg

// *** gss_far_end.sv ***
// Far-end serial device model: makes clock, trigger and receive data
`timescale 1ns/10ps
`default_nettype none
module gss_far_end
(
  input  wire logic clk_in,
  input  wire logic serial_out_pin_in,
  output logic      transfer_clock_pin_out,
  output logic      sync_trigger_pin_n_out,
  output logic      serial_in_pin_out
);
  localparam int HALF = 10;
  initial
  begin
    transfer_clock_pin_out = 1'h0;
    sync_trigger_pin_n_out = 1'h1;
    serial_in_pin_out      = 1'h1;
  end
  // One full external clock period with no data action
  task automatic pulse;
    transfer_clock_pin_out <= 1'h1;
    repeat (HALF) @(posedge clk_in);
    transfer_clock_pin_out <= 1'h0;
    repeat (HALF) @(posedge clk_in);
  endtask : pulse
  // Clock stands low outside frames; trigger aligns the channel
  // Two set: each bit spans two external periods, and one more closes the word
  task automatic frame(input logic two, input logic [7:0] rx, output logic [7:0] tx);
    int i;
    begin
      serial_in_pin_out <= rx[0];
      @(posedge clk_in);
      sync_trigger_pin_n_out <= 1'h0;
      repeat (HALF) @(posedge clk_in);
      for (i = 0; i < 8; i++) // Eight bits, LSB first, no framing
      begin
        if (two)
          pulse;
        transfer_clock_pin_out <= 1'h1;
        tx[i] = serial_out_pin_in;
        repeat (HALF) @(posedge clk_in);
        transfer_clock_pin_out <= 1'h0;
        repeat (HALF / 2) @(posedge clk_in);
        // Released line shows the inverse so a stale bit cannot pass
        serial_in_pin_out <= (i < 7) ? rx[i + 1] : ~rx[7];
        repeat (HALF / 2) @(posedge clk_in);
      end
      if (two)
        pulse;
      sync_trigger_pin_n_out <= 1'h1;
      repeat (6) @(posedge clk_in);
    end
  endtask : frame
endmodule : gss_far_end
`default_nettype wire

// *** gss_sync_serial_port_bench.sv ***
// Self-checking bench for the synchronous serial channel
`timescale 1ns/10ps
`default_nettype none
module gss_sync_serial_port_bench;
  import gss_pkg::*;
  logic        clk_in  = 1'h0;
  logic        rst_in  = 1'h1;
  logic [7:0]  paddr   = 8'h00;
  logic        psel    = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite  = 1'h0;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, tclk, trig_n, rxd, txd, txoe, irq, last_err;
  logic [7:0]  txw;
  int          n_mismatch      = 0;
  int          samples_checked = 0;
  always #2.5 clk_in = ~clk_in;
  gss_sync_serial_port uut (.clk_in(clk_in), .rst_in(rst_in), .paddr_in(paddr),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .transfer_clock_pin_in(tclk), .sync_trigger_pin_n_in(trig_n),
    .serial_in_pin_in(rxd), .serial_out_pin_out(txd),
    .serial_out_pin_oe_out(txoe), .irq_out(irq));
  gss_far_end far (.clk_in(clk_in), .serial_out_pin_in(txd),
    .transfer_clock_pin_out(tclk), .sync_trigger_pin_n_out(trig_n),
    .serial_in_pin_out(rxd));
  task automatic test_done;
    $display("mismatches %0d of %0d checks", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : test_done
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // One APB transfer; the request holds until pready is seen at an edge
  task automatic apb(input logic wr_en, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= wr_en;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_in);
    penable <= 1'h1;
    do @(posedge clk_in); while (pready !== 1'h1);
    rd       = prdata;
    last_err = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
    @(posedge clk_in);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'h1, a, d, r);
  endtask : wr
  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] exp);
    logic [31:0] r;
    apb(1'h0, a, 32'h0, r);
    check(what, exp, r & m);
  endtask : rdchk
  task automatic cfg(input logic irs, input logic stop);
    wr(GSS_A_MODE, 32'h8);
    wr(GSS_A_SMR2, 32'h80);
    wr(GSS_A_CTL1, {26'h0, stop, irs, 4'h5});
  endtask : cfg
  task automatic t_regs;
    rdchk("ctl0 reset", GSS_A_CTL0, 32'h18, 32'h18);
    rdchk("tbe reset", GSS_A_CTL1, 32'h2, 32'h2);
    wr(GSS_A_CTL0, 32'h20);
    rdchk("flow disable", GSS_A_CTL0, 32'h10, 32'h10);
    rdchk("unmapped", 8'h30, 32'hFFFFFFFF, 32'h0);
    check("unmapped err", 32'h1, {31'h0, last_err});
  endtask : t_regs
  task automatic t_word;
    cfg(1'h0, 1'h0);
    wr(GSS_A_IMSK, 32'h3);
    wr(GSS_A_TXBUF, 32'hA5);
    rdchk("tbe full", GSS_A_CTL1, 32'h2, 32'h0);
    fork
      far.frame(1'h0, 8'h3C, txw);
      begin
        repeat (60) @(posedge clk_in);
        rdchk("tx irq at load", GSS_A_IST, 32'h1, 32'h1);
        rdchk("shifter busy", GSS_A_CTL0, 32'h8, 32'h0);
      end
    join
    check("tx word", 32'hA5, {24'h0, txw});
    rdchk("rx word", GSS_A_RXBUF, 32'hFF, 32'h3C);
    rdchk("rx status", GSS_A_IST, 32'h2, 32'h2);
    check("irq on", 32'h1, {31'h0, irq});
    wr(GSS_A_IMSK, 32'h0);
    check("irq masked", 32'h0, {31'h0, irq});
    wr(GSS_A_IMSK, 32'h3);
    wr(GSS_A_IST, 32'h7);
    check("irq cleared", 32'h0, {31'h0, irq});
    wr(GSS_A_CTL0, 32'h4);
    check("open drain idle", 32'h0, {31'h0, txoe});
    wr(GSS_A_CTL0, 32'h0);
  endtask : t_word
  task automatic t_irs1;
    cfg(1'h1, 1'h0);
    wr(GSS_A_TXBUF, 32'h5A);
    fork
      far.frame(1'h0, 8'h96, txw);
      begin
        repeat (60) @(posedge clk_in);
        rdchk("tx irq early", GSS_A_IST, 32'h1, 32'h0);
      end
    join
    rdchk("tx irq at end", GSS_A_IST, 32'h1, 32'h1);
    rdchk("shifter empty", GSS_A_CTL0, 32'h8, 32'h8);
    check("tx word 2", 32'h5A, {24'h0, txw});
    rdchk("rx word 2", GSS_A_RXBUF, 32'hFF, 32'h96);
    wr(GSS_A_IST, 32'h7);
  endtask : t_irs1
  task automatic t_overrun;
    cfg(1'h0, 1'h0);
    wr(GSS_A_TXBUF, 32'h11);
    far.frame(1'h0, 8'h81, txw);
    wr(GSS_A_IST, 32'h7);
    wr(GSS_A_TXBUF, 32'h22);
    far.frame(1'h0, 8'h42, txw);
    rdchk("overrun status", GSS_A_IST, 32'h6, 32'h4);
    rdchk("overrun flag", GSS_A_RXBUF, 32'h8000, 32'h8000);
    wr(GSS_A_CTL1, 32'h0);
    rdchk("overrun clear", GSS_A_RXBUF, 32'h8000, 32'h0);
  endtask : t_overrun
  // Half-rate derived clock: two external periods per bit
  task automatic t_half;
    cfg(1'h1, 1'h0);
    wr(GSS_A_SMR1, 32'h80);
    wr(GSS_A_IST, 32'h7);
    wr(GSS_A_TXBUF, 32'hC3);
    far.frame(1'h1, 8'h69, txw);
    check("half tx word", 32'hC3, {24'h0, txw});
    rdchk("half rx word", GSS_A_RXBUF, 32'hFF, 32'h69);
    rdchk("half done irqs", GSS_A_IST, 32'h3, 32'h3);
    wr(GSS_A_SMR1, 32'h0);
  endtask : t_half
  // Enable off, clock stopped, clock source internal: no word may start
  task automatic t_refused;
    logic [31:0] ctl [3];
    logic [31:0] mode [3];
    int          k;
    ctl  = '{32'h4, 32'h25, 32'h5};
    mode = '{32'h8, 32'h8, 32'h0};
    wr(GSS_A_TXBUF, 32'h33);
    for (k = 0; k < 3; k++)
    begin
      wr(GSS_A_MODE, mode[k]);
      wr(GSS_A_CTL1, ctl[k]);
      wr(GSS_A_IST, 32'h7);
      far.frame(1'h0, 8'h55, txw);
      rdchk("no start", GSS_A_IST, 32'h3, 32'h0);
      rdchk("buffer kept", GSS_A_CTL1, 32'h2, 32'h0);
    end
  endtask : t_refused
  initial
  begin
    repeat (10) @(posedge clk_in);
    rst_in <= 1'h0;
    @(posedge clk_in);
    t_regs;
    t_word;
    t_irs1;
    t_overrun;
    t_half;
    t_refused;
    test_done;
  end
  // About 1800 cycles are expected; a hang stops well beyond that
  initial
  begin
    repeat (30000) @(posedge clk_in);
    n_mismatch++;
    test_done;
  end
endmodule : gss_sync_serial_port_bench
`default_nettype wire
